// *** src/cpu8_alu.sv ***
`timescale 1ns/1ps
module cpu8_alu (
  input cpu8_pkg::alu_op_e op,
  input wire logic [7:0] opnd,
  input wire logic [7:0] acc,
  input cpu8_pkg::flags_s flags_in,
  output logic [7:0] result,
  output cpu8_pkg::flags_s flags_out
);
  always_comb begin
    flags_out = flags_in;
    result = opnd;
    case (op)
      cpu8_pkg::ALU_OR: begin
        result = acc | opnd;
        flags_out.v = 1'b0;
      end
      cpu8_pkg::ALU_SHL: begin
        result = {opnd[6:0], 1'b0};
        flags_out.c = opnd[7];
        flags_out.v = result[7] ^ opnd[7];
      end
      cpu8_pkg::ALU_SHR: begin
        result = {1'b0, opnd[7:1]};
        flags_out.c = opnd[0];
        // N is forced low, so V reduces to the carry
        flags_out.v = opnd[0];
      end
      cpu8_pkg::ALU_NEG: begin
        result = 8'h00 - opnd;
        flags_out.c = |result;
        flags_out.v = result[7] & opnd[7];
      end
      default: begin
        flags_out.v = 1'b0;
      end
    endcase
    flags_out.n = result[7];
    flags_out.z = ~|result;
  end
endmodule // cpu8_alu

// *** src/cpu8_core.sv ***
// What this block does
// [RL1] One 8-bit accumulator holds operands and results
// [RL2] 16-bit index as high and low bytes
// [RL3] Indexed modes address through the index pair
// [RL4] Core registers invisible to the memory bus
// [RL5] Load index low byte, V cleared, N Z
// [RL6] Left shift: zero in, bit 7 to carry
// [RL7] Right shift: zero in, bit 0 to carry
// [RL8] Memory move, four forms, index post-increment
// [RL9] Negate operand as zero minus it
// [RL10] OR byte into accumulator, V cleared
// [RL11] Push writes stack then decrements pointer
// [RL12] Pull increments pointer then loads accumulator
`timescale 1ns/1ps
`include "cpu8_params.svh"
module cpu8_core (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output cpu8_pkg::mem_req_s mem_req,
  input wire logic [7:0] mem_rdata
);
  cpu8_pkg::state_e state;
  cpu8_pkg::mode_e mode_q;
  cpu8_pkg::mode_e dec_mode;
  cpu8_pkg::mode_e cur_mode;
  cpu8_pkg::ins_e ins_q;
  cpu8_pkg::ins_e dec_ins;
  cpu8_pkg::ins_e cur_ins;
  cpu8_pkg::alu_op_e alu_op;
  cpu8_pkg::flags_s flags;
  cpu8_pkg::flags_s alu_flags;
  // Core registers live only here; no bus path reaches them
  logic [7:0] acc; // RL1 RL4
  logic [7:0] idx_hi;
  logic [7:0] idx_lo;
  logic [15:0] stack_pointer;
  logic [15:0] pc;
  logic [15:0] ea;
  logic [7:0] b1;
  logic [7:0] mv_data;
  logic [7:0] last_opc;
  logic [7:0] alu_in;
  logic [7:0] alu_res;
  logic [7:0] push_data;
  logic [15:0] hx;
  logic pre;
  logic run;
  logic bad;
  logic op_cycle;
  logic exec_now;
  logic apb_wr;
  logic apb_access;
  logic mapped;

  assign hx = {idx_hi, idx_lo}; // RL2
  assign op_cycle = (state == cpu8_pkg::S_OPC) && !(mem_rdata == `OPC_PREFIX && !pre);
  assign cur_mode = (state == cpu8_pkg::S_OPC) ? dec_mode : mode_q;
  assign cur_ins = (state == cpu8_pkg::S_OPC) ? dec_ins : ins_q;

  ////////////////////////////////////////////////////////////////////////////
  // Opcode decode, prefix byte folded in
  always_comb begin
    dec_mode = cpu8_pkg::M_BAD;
    dec_ins = cpu8_pkg::INS_NONE;
    if (pre) begin
      case (mem_rdata[3:0])
        `NIB_LOAD_LOW: dec_ins = cpu8_pkg::INS_LOAD_INDEX_LOW;
        `NIB_OR_ACC: dec_ins = cpu8_pkg::INS_OR_INTO_ACCUMULATOR;
        `NIB_SHL: dec_ins = cpu8_pkg::INS_SHIFT_LEFT_LOGICAL;
        `NIB_SHR: dec_ins = cpu8_pkg::INS_SHIFT_RIGHT_LOGICAL;
        `NIB_NEG: dec_ins = cpu8_pkg::INS_TWOS_NEGATE;
        default: dec_ins = cpu8_pkg::INS_NONE;
      endcase
      case (mem_rdata[7:4])
        4'hE: dec_mode = cpu8_pkg::M_STK1;
        4'hD: dec_mode = cpu8_pkg::M_STK2;
        4'h6: dec_mode = cpu8_pkg::M_STK1;
        default: dec_mode = cpu8_pkg::M_BAD;
      endcase
      // Stack-relative two-byte offset exists only for load and OR
      if (mem_rdata[7:4] == 4'h6 && mem_rdata[3:0] inside {`NIB_LOAD_LOW, `NIB_OR_ACC}) begin
        dec_mode = cpu8_pkg::M_BAD;
      end
      if (mem_rdata[7:4] != 4'h6 && !(mem_rdata[3:0] inside {`NIB_LOAD_LOW, `NIB_OR_ACC})) begin
        dec_mode = cpu8_pkg::M_BAD;
      end
    end else if (mem_rdata == `OPC_PUSH_ACC) begin
      dec_ins = cpu8_pkg::INS_PUSH_ACCUMULATOR;
      dec_mode = cpu8_pkg::M_PUSH;
    end else if (mem_rdata == `OPC_PUSH_HIGH) begin
      dec_ins = cpu8_pkg::INS_PUSH_INDEX_HIGH;
      dec_mode = cpu8_pkg::M_PUSH;
    end else if (mem_rdata == `OPC_PUSH_LOW) begin
      dec_ins = cpu8_pkg::INS_PUSH_INDEX_LOW;
      dec_mode = cpu8_pkg::M_PUSH;
    end else if (mem_rdata == `OPC_PULL_ACC) begin
      dec_ins = cpu8_pkg::INS_PULL_ACCUMULATOR;
      dec_mode = cpu8_pkg::M_PULL;
    end else if (mem_rdata == `OPC_MOVE_DD) begin
      dec_ins = cpu8_pkg::INS_MEMORY_MOVE;
      dec_mode = cpu8_pkg::M_DIR_DIR;
    end else if (mem_rdata == `OPC_MOVE_DIXP) begin
      dec_ins = cpu8_pkg::INS_MEMORY_MOVE;
      dec_mode = cpu8_pkg::M_DIR_IXP;
    end else if (mem_rdata == `OPC_MOVE_IMD) begin
      dec_ins = cpu8_pkg::INS_MEMORY_MOVE;
      dec_mode = cpu8_pkg::M_IMM_DIR;
    end else if (mem_rdata == `OPC_MOVE_IXPD) begin
      dec_ins = cpu8_pkg::INS_MEMORY_MOVE;
      dec_mode = cpu8_pkg::M_IXP_DIR;
    end else if (mem_rdata[3:0] inside {`NIB_LOAD_LOW, `NIB_OR_ACC}) begin
      dec_ins = (mem_rdata[3:0] == `NIB_LOAD_LOW) ? cpu8_pkg::INS_LOAD_INDEX_LOW :
                cpu8_pkg::INS_OR_INTO_ACCUMULATOR;
      case (mem_rdata[7:4])
        4'hA: dec_mode = cpu8_pkg::M_IMM;
        4'hB: dec_mode = cpu8_pkg::M_DIR;
        4'hC: dec_mode = cpu8_pkg::M_EXT;
        4'hD: dec_mode = cpu8_pkg::M_IX2;
        4'hE: dec_mode = cpu8_pkg::M_IX1;
        4'hF: dec_mode = cpu8_pkg::M_IX;
        default: dec_mode = cpu8_pkg::M_BAD;
      endcase
    end else if (mem_rdata[3:0] inside {`NIB_SHL, `NIB_SHR, `NIB_NEG}) begin
      dec_ins = (mem_rdata[3:0] == `NIB_SHL) ? cpu8_pkg::INS_SHIFT_LEFT_LOGICAL :
                (mem_rdata[3:0] == `NIB_SHR) ? cpu8_pkg::INS_SHIFT_RIGHT_LOGICAL :
                cpu8_pkg::INS_TWOS_NEGATE;
      case (mem_rdata[7:4])
        4'h3: dec_mode = cpu8_pkg::M_DIR;
        4'h4: dec_mode = cpu8_pkg::M_INHA;
        4'h5: dec_mode = cpu8_pkg::M_INHX;
        4'h6: dec_mode = cpu8_pkg::M_IX1;
        4'h7: dec_mode = cpu8_pkg::M_IX;
        default: dec_mode = cpu8_pkg::M_BAD;
      endcase
    end
    if (dec_mode == cpu8_pkg::M_BAD) begin
      dec_ins = cpu8_pkg::INS_NONE;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Operand and result path
  always_comb begin
    case (cur_ins)
      cpu8_pkg::INS_OR_INTO_ACCUMULATOR: alu_op = cpu8_pkg::ALU_OR;
      cpu8_pkg::INS_SHIFT_LEFT_LOGICAL: alu_op = cpu8_pkg::ALU_SHL;
      cpu8_pkg::INS_SHIFT_RIGHT_LOGICAL: alu_op = cpu8_pkg::ALU_SHR;
      cpu8_pkg::INS_TWOS_NEGATE: alu_op = cpu8_pkg::ALU_NEG;
      default: alu_op = cpu8_pkg::ALU_PASS;
    endcase
    alu_in = (cur_mode == cpu8_pkg::M_INHA) ? acc :
             (cur_mode == cpu8_pkg::M_INHX) ? idx_lo : mem_rdata;
    push_data = (cur_ins == cpu8_pkg::INS_PUSH_ACCUMULATOR) ? acc :
                (cur_ins == cpu8_pkg::INS_PUSH_INDEX_HIGH) ? idx_hi : idx_lo;
    exec_now = (op_cycle && cur_mode inside {cpu8_pkg::M_INHA, cpu8_pkg::M_INHX}) ||
               (state == cpu8_pkg::S_B1 && mode_q inside {cpu8_pkg::M_IMM, cpu8_pkg::M_IMM_DIR}) ||
               (state == cpu8_pkg::S_OPR);
  end

  cpu8_alu alu (
    .op(alu_op),
    .opnd(alu_in),
    .acc(acc),
    .flags_in(flags),
    .result(alu_res),
    .flags_out(alu_flags)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Core registers
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      acc <= 8'h00;
      idx_hi <= 8'h00;
      idx_lo <= 8'h00;
      stack_pointer <= `SP_RESET;
      flags <= `FLAGS_RESET;
    end else begin
      if (op_cycle && cur_mode == cpu8_pkg::M_PUSH) begin
        stack_pointer <= stack_pointer - 16'h0001; // RL11
      end
      if (op_cycle && cur_mode == cpu8_pkg::M_PULL) begin
        stack_pointer <= stack_pointer + 16'h0001; // RL12
      end
      if (exec_now) begin
        case (cur_ins)
          cpu8_pkg::INS_LOAD_INDEX_LOW: begin
            idx_lo <= alu_res; // RL5
            flags <= alu_flags;
          end
          cpu8_pkg::INS_OR_INTO_ACCUMULATOR: begin
            acc <= alu_res; // RL10
            flags <= alu_flags;
          end
          cpu8_pkg::INS_SHIFT_LEFT_LOGICAL, cpu8_pkg::INS_SHIFT_RIGHT_LOGICAL,
          cpu8_pkg::INS_TWOS_NEGATE: begin
            if (cur_mode == cpu8_pkg::M_INHA) begin
              acc <= alu_res; // RL6 RL7 RL9
            end
            if (cur_mode == cpu8_pkg::M_INHX) begin
              idx_lo <= alu_res;
            end
            flags <= alu_flags;
          end
          cpu8_pkg::INS_MEMORY_MOVE: begin
            flags <= alu_flags; // RL8
            if (cur_mode inside {cpu8_pkg::M_DIR_IXP, cpu8_pkg::M_IXP_DIR}) begin
              {idx_hi, idx_lo} <= hx + 16'h0001; // RL8
            end
          end
          cpu8_pkg::INS_PULL_ACCUMULATOR: acc <= mem_rdata; // RL12
          default: acc <= acc;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer; bus request is registered, read data is used in the next cycle
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      state <= cpu8_pkg::S_IDLE;
      mem_req <= '0;
      pc <= `PC_RESET;
      pre <= 1'b0;
      ins_q <= cpu8_pkg::INS_NONE;
      mode_q <= cpu8_pkg::M_BAD;
      ea <= 16'h0000;
      b1 <= 8'h00;
      mv_data <= 8'h00;
    end else begin
      // Default: fetch the next opcode, or park when software stopped the core
      mem_req <= '{addr: pc, rd: run, wr: 1'b0, wdata: 8'h00};
      pc <= pc + {15'h0000, run};
      state <= run ? cpu8_pkg::S_OPC : cpu8_pkg::S_IDLE;
      case (state)
        cpu8_pkg::S_IDLE: pre <= 1'b0;
        cpu8_pkg::S_OPC: begin
          ins_q <= dec_ins;
          mode_q <= dec_mode;
          pre <= 1'b0;
          if (!op_cycle) begin
            // Prefix seen: fetch the second opcode byte regardless of run
            pre <= 1'b1;
            mem_req <= '{addr: pc, rd: 1'b1, wr: 1'b0, wdata: 8'h00};
            pc <= pc + 16'h0001;
            state <= cpu8_pkg::S_OPC;
          end else if (dec_mode inside {cpu8_pkg::M_IX, cpu8_pkg::M_IXP_DIR}) begin
            ea <= hx;
            mem_req <= '{addr: hx, rd: 1'b1, wr: 1'b0, wdata: 8'h00}; // RL3
            pc <= pc;
            state <= cpu8_pkg::S_OPR;
          end else if (dec_mode == cpu8_pkg::M_PUSH) begin
            mem_req <= '{addr: stack_pointer, rd: 1'b0, wr: 1'b1, wdata: push_data}; // RL11
            pc <= pc;
            state <= cpu8_pkg::S_WB;
          end else if (dec_mode == cpu8_pkg::M_PULL) begin
            mem_req <= '{addr: stack_pointer + 16'h0001, rd: 1'b1, wr: 1'b0, wdata: 8'h00};
            pc <= pc;
            state <= cpu8_pkg::S_OPR;
          end else if (!(dec_mode inside {cpu8_pkg::M_INHA, cpu8_pkg::M_INHX,
                                          cpu8_pkg::M_BAD})) begin
            mem_req <= '{addr: pc, rd: 1'b1, wr: 1'b0, wdata: 8'h00};
            pc <= pc + 16'h0001;
            state <= cpu8_pkg::S_B1;
          end
        end
        cpu8_pkg::S_B1: begin
          b1 <= mem_rdata;
          if (mode_q != cpu8_pkg::M_IMM) begin
            mem_req.rd <= 1'b1;
            pc <= pc;
            state <= cpu8_pkg::S_OPR;
            case (mode_q)
              cpu8_pkg::M_IMM_DIR, cpu8_pkg::M_EXT, cpu8_pkg::M_IX2, cpu8_pkg::M_STK2: begin
                mv_data <= mem_rdata;
                pc <= pc + 16'h0001;
                state <= (mode_q == cpu8_pkg::M_IMM_DIR) ? cpu8_pkg::S_DST : cpu8_pkg::S_B2;
              end
              cpu8_pkg::M_IX1: begin
                ea <= hx + {8'h00, mem_rdata}; // RL3
                mem_req.addr <= hx + {8'h00, mem_rdata};
              end
              cpu8_pkg::M_STK1: begin
                ea <= stack_pointer + {8'h00, mem_rdata};
                mem_req.addr <= stack_pointer + {8'h00, mem_rdata};
              end
              default: begin
                ea <= {8'h00, mem_rdata};
                mem_req.addr <= {8'h00, mem_rdata};
              end
            endcase
          end
        end
        cpu8_pkg::S_B2: begin
          mem_req.rd <= 1'b1;
          pc <= pc;
          state <= cpu8_pkg::S_OPR;
          if (mode_q == cpu8_pkg::M_IX2) begin
            ea <= hx + {b1, mem_rdata}; // RL3
            mem_req.addr <= hx + {b1, mem_rdata};
          end else if (mode_q == cpu8_pkg::M_STK2) begin
            ea <= stack_pointer + {b1, mem_rdata};
            mem_req.addr <= stack_pointer + {b1, mem_rdata};
          end else begin
            ea <= {b1, mem_rdata};
            mem_req.addr <= {b1, mem_rdata};
          end
        end
        cpu8_pkg::S_OPR: begin
          if (ins_q inside {cpu8_pkg::INS_SHIFT_LEFT_LOGICAL, cpu8_pkg::INS_SHIFT_RIGHT_LOGICAL,
                            cpu8_pkg::INS_TWOS_NEGATE}) begin
            mem_req <= '{addr: ea, rd: 1'b0, wr: 1'b1, wdata: alu_res}; // RL6 RL7 RL9
            pc <= pc;
            state <= cpu8_pkg::S_WB;
          end else if (mode_q == cpu8_pkg::M_DIR_IXP) begin
            mem_req <= '{addr: hx, rd: 1'b0, wr: 1'b1, wdata: mem_rdata}; // RL8
            pc <= pc;
            state <= cpu8_pkg::S_WB;
          end else if (ins_q == cpu8_pkg::INS_MEMORY_MOVE) begin
            mv_data <= mem_rdata;
            mem_req <= '{addr: pc, rd: 1'b1, wr: 1'b0, wdata: 8'h00};
            pc <= pc + 16'h0001;
            state <= cpu8_pkg::S_DST;
          end
        end
        cpu8_pkg::S_DST: begin
          mem_req <= '{addr: {8'h00, mem_rdata}, rd: 1'b0, wr: 1'b1, wdata: mv_data}; // RL8
          pc <= pc;
          state <= cpu8_pkg::S_WB;
        end
        default: pre <= 1'b0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB slave: control, status, last opcode
  assign apb_access = psel && penable;
  assign apb_wr = apb_access && pwrite;
  assign mapped = paddr == `REG_CTRL || paddr == `REG_STATUS || paddr == `REG_OPCODE;
  assign pready = apb_access;
  assign pslverr = apb_access && !mapped;

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      run <= 1'b0;
      bad <= 1'b0;
      last_opc <= 8'h00;
    end else begin
      if (apb_wr && paddr == `REG_CTRL) begin
        run <= pwdata[`CTRL_RUN_BIT];
      end
      if (op_cycle) begin
        last_opc <= mem_rdata;
      end
      // Undefined opcode is skipped; its flag survives a same-cycle clear
      if (apb_wr && paddr == `REG_STATUS && pwdata[`STAT_BAD_BIT]) begin
        bad <= 1'b0;
      end
      if (op_cycle && dec_mode == cpu8_pkg::M_BAD) begin
        bad <= 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      prdata <= 32'h00000000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= 32'h00000000;
      if (paddr == `REG_CTRL) begin
        prdata[`CTRL_RUN_BIT] <= run;
      end else if (paddr == `REG_STATUS) begin
        prdata[`STAT_BUSY_BIT] <= state != cpu8_pkg::S_IDLE;
        prdata[`STAT_BAD_BIT] <= bad;
      end else if (paddr == `REG_OPCODE) begin
        prdata[7:0] <= last_opc;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  // Keyed on exec_now so immediate forms are checked as well
  a_or_result: assert property (exec_now && cur_ins == cpu8_pkg::INS_OR_INTO_ACCUMULATOR // RL10
    |=> acc == ($past(acc) | $past(mem_rdata)) && !flags.v)
    else $error("OR result wrong");
  a_load_low: assert property (exec_now && cur_ins == cpu8_pkg::INS_LOAD_INDEX_LOW // RL5
    |=> idx_lo == $past(mem_rdata) && !flags.v && flags.z == (idx_lo == 8'h00))
    else $error("Index load wrong");
  a_push_order: assert property (op_cycle && dec_mode == cpu8_pkg::M_PUSH // RL11
    |=> mem_req.wr && mem_req.addr == $past(stack_pointer)
    && stack_pointer == $past(stack_pointer) - 16'h0001
    ##1 state == cpu8_pkg::S_OPC || state == cpu8_pkg::S_IDLE)
    else $error("Push order wrong");
  a_pull_order: assert property (op_cycle && dec_mode == cpu8_pkg::M_PULL // RL12
    |=> mem_req.addr == stack_pointer ##1 acc == $past(mem_rdata) && flags == $past(flags, 2))
    else $error("Pull order wrong");
  a_ix_addr: assert property (op_cycle // RL3
    && dec_mode inside {cpu8_pkg::M_IX, cpu8_pkg::M_IXP_DIR}
    |=> mem_req.rd && mem_req.addr == $past(hx))
    else $error("Indexed address wrong");
  a_move_incr: assert property (state == cpu8_pkg::S_OPR // RL8
    && mode_q == cpu8_pkg::M_DIR_IXP
    |=> mem_req.wr && mem_req.addr == hx - 16'h0001 && mem_req.wdata == $past(mem_rdata))
    else $error("Move post-increment wrong");
  a_shl_carry: assert property (state == cpu8_pkg::S_OPR // RL6
    && ins_q == cpu8_pkg::INS_SHIFT_LEFT_LOGICAL
    |=> flags.c == $past(mem_rdata[7]) && mem_req.wdata == {$past(mem_rdata[6:0]), 1'b0})
    else $error("Left shift wrong");
  a_shr_neg: assert property (state == cpu8_pkg::S_OPR // RL7
    && ins_q == cpu8_pkg::INS_SHIFT_RIGHT_LOGICAL
    |=> !flags.n && flags.c == $past(mem_rdata[0])
    && mem_req.wdata == {1'b0, $past(mem_rdata[7:1])})
    else $error("Right shift wrong");
  a_neg_value: assert property (state == cpu8_pkg::S_OPR // RL9
    && ins_q == cpu8_pkg::INS_TWOS_NEGATE
    |=> mem_req.wdata == 8'h00 - $past(mem_rdata) && flags.c == ($past(mem_rdata) != 8'h00))
    else $error("Negate wrong");
  a_inh_single: assert property (op_cycle && dec_mode == cpu8_pkg::M_INHA && run // RL6
    |=> state == cpu8_pkg::S_OPC && !mem_req.wr)
    else $error("Inherent op not one cycle");
endmodule // cpu8_core

// *** src/cpu8_params.svh ***
`ifndef CPU8_PARAMS_SVH
`define CPU8_PARAMS_SVH

// Register offsets on the APB slave
`define REG_CTRL 12'h000
`define REG_STATUS 12'h004
`define REG_OPCODE 12'h008
`define CTRL_RUN_BIT 0
`define STAT_BUSY_BIT 0
`define STAT_BAD_BIT 1

// Reset values of the core
`define PC_RESET 16'h0000
`define SP_RESET 16'h00FF
`define FLAGS_RESET 6'h08

// Opcodes
`define OPC_PREFIX 8'h9E
`define OPC_PUSH_ACC 8'h87
`define OPC_PUSH_HIGH 8'h8B
`define OPC_PUSH_LOW 8'h89
`define OPC_PULL_ACC 8'h86
`define OPC_MOVE_DD 8'h4E
`define OPC_MOVE_DIXP 8'h5E
`define OPC_MOVE_IMD 8'h6E
`define OPC_MOVE_IXPD 8'h7E
`define NIB_LOAD_LOW 4'hE
`define NIB_OR_ACC 4'hA
`define NIB_SHL 4'h8
`define NIB_SHR 4'h4
`define NIB_NEG 4'h0

`endif

// *** src/cpu8_pkg.sv ***
package cpu8_pkg;
  typedef enum logic [2:0] {S_IDLE, S_OPC, S_B1, S_B2, S_OPR, S_DST, S_WB} state_e;
  typedef enum logic [4:0] {
    M_INHA, M_INHX, M_IMM, M_DIR, M_EXT, M_IX, M_IX1, M_IX2, M_STK1, M_STK2,
    M_DIR_DIR, M_DIR_IXP, M_IMM_DIR, M_IXP_DIR, M_PUSH, M_PULL, M_BAD
  } mode_e;
  typedef enum logic [3:0] {
    INS_LOAD_INDEX_LOW, INS_OR_INTO_ACCUMULATOR, INS_SHIFT_LEFT_LOGICAL,
    INS_SHIFT_RIGHT_LOGICAL, INS_TWOS_NEGATE, INS_MEMORY_MOVE, INS_PUSH_ACCUMULATOR,
    INS_PUSH_INDEX_HIGH, INS_PUSH_INDEX_LOW, INS_PULL_ACCUMULATOR, INS_NONE
  } ins_e;
  typedef enum logic [2:0] {ALU_PASS, ALU_OR, ALU_SHL, ALU_SHR, ALU_NEG} alu_op_e;
  typedef struct packed {
    logic v;
    logic h;
    logic i;
    logic n;
    logic z;
    logic c;
  } flags_s;
  typedef struct packed {
    logic [15:0] addr;
    logic rd;
    logic wr;
    logic [7:0] wdata;
  } mem_req_s;
endpackage

// *** tb/mem_model.sv ***
`timescale 1ns/1ps
module mem_model (
  input wire logic ref_clk,
  input cpu8_pkg::mem_req_s mem_req,
  output logic [7:0] mem_rdata
);
  // Flat 64K byte space, zero wait states, written by the bench at time zero
  logic [7:0] cells [0:65535];
  logic [7:0] last = 8'h00;
  ////////////////////////////////////////////////////////////////
  // Plain always: the bench preloads cells, so this is not the only writer
  always @(posedge ref_clk) begin
    if (mem_req.wr) begin
      cells[mem_req.addr] <= mem_req.wdata;
    end
    if (mem_req.rd) begin
      last <= cells[mem_req.addr];
    end
  end
  // Not selected: show inverse of last byte so stale data never looks valid
  always_comb mem_rdata = mem_req.rd ? cells[mem_req.addr] : ~last;
endmodule // mem_model

// *** tb/testbench.sv ***
`timescale 1ns/1ps
module testbench;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  cpu8_pkg::mem_req_s mem_req;
  logic [7:0] mem_rdata;
  int n_mismatch = 0;
  int checks = 0;
  int cyc = 0;
  int t0 = -1;
  int t1 = -1;
  logic [31:0] rd;
  logic err;
  // Program bytes from address 0000; ends at 0020
  logic [7:0] prog [0:32] = '{8'hAE, 8'h80, 8'h89, 8'hAA, 8'h01, 8'h48, 8'h44, 8'h40,
    8'h87, 8'h86, 8'h48, 8'h87, 8'h6E, 8'h5A, 8'h60, 8'h38, 8'h60, 8'h30, 8'h61,
    8'h4E, 8'h60, 8'h62, 8'h7E, 8'h70, 8'h89, 8'h8B, 8'h5E, 8'h70, 8'h34, 8'h81,
    8'h9E, 8'h64, 8'h05};

  always #5 ref_clk = ~ref_clk;

  cpu8_core cpu8_core_inst (.ref_clk(ref_clk), .rst_b(rst_b), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .mem_req(mem_req),
    .mem_rdata(mem_rdata));
  mem_model mem_model_inst (.ref_clk(ref_clk), .mem_req(mem_req), .mem_rdata(mem_rdata));

  ////////////////////////////////////////////////////////////////
  // Cycle stamps of first fetch and of fetch past program end
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (mem_req.rd === 1'b1 && mem_req.addr === 16'h0000 && t0 < 0) t0 <= cyc;
    if (mem_req.rd === 1'b1 && mem_req.addr === 16'h0021 && t1 < 0) t1 <= cyc;
    if (cyc >= 5000) begin
      n_mismatch++;
      test_done();
    end
  end

  task automatic test_done();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // One APB transfer; request held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
    output logic [31:0] r, output logic e);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    // No wait-state count assumed; the cycle ceiling ends a hang
    do begin
      @(posedge ref_clk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////
  initial begin
    int i;
    for (i = 0; i < 65536; i++) mem_model_inst.cells[i] = 8'h00;
    for (i = 0; i < 33; i++) mem_model_inst.cells[i] = prog[i];
    mem_model_inst.cells[16'h0061] = 8'h01;
    mem_model_inst.cells[16'h0080] = 8'hC3;
    mem_model_inst.cells[16'h0100] = 8'h81;
    repeat (10) @(posedge ref_clk);
    rst_b <= 1'b1;
    apb(1'b0, 12'h004, 32'h0, rd, err);
    chk("status_reset", rd, 32'h00000000);
    apb(1'b0, 12'h00C, 32'h0, rd, err);
    chk("unmapped_data", rd, 32'h00000000);
    chk("unmapped_err", {31'h0, err}, 32'h00000001);
    apb(1'b1, 12'h000, 32'h00000001, rd, err);
    while (t1 < 0) begin
      @(posedge ref_clk);
    end
    // Stop before the program counter walks into the data bytes at 0060
    apb(1'b1, 12'h000, 32'h00000000, rd, err);
    do begin
      apb(1'b0, 12'h004, 32'h0, rd, err);
    end while (rd[0] !== 1'b0);
    chk("cycle_total", t1 - t0, 32'd54);
    chk("push_low", mem_model_inst.cells[16'h00FF], 8'h80);
    chk("pull_then_push", mem_model_inst.cells[16'h00FE], 8'hFE);
    chk("move_imm_shl", mem_model_inst.cells[16'h0060], 8'hB4);
    chk("neg_mem", mem_model_inst.cells[16'h0061], 8'hFF);
    chk("move_dd", mem_model_inst.cells[16'h0062], 8'hB4);
    chk("move_ixp", mem_model_inst.cells[16'h0070], 8'hC3);
    chk("index_incr", mem_model_inst.cells[16'h00FD], 8'h81);
    chk("push_high", mem_model_inst.cells[16'h00FC], 8'h00);
    chk("stack_floor", mem_model_inst.cells[16'h00FB], 8'h00);
    chk("move_dixp_shr", mem_model_inst.cells[16'h0081], 8'h61);
    chk("shr_stack_rel", mem_model_inst.cells[16'h0100], 8'h40);
    // Opcode 00 past the end is undefined here and sets the sticky bit
    chk("status_bad", rd, 32'h00000002);
    apb(1'b1, 12'h004, 32'h00000002, rd, err);
    apb(1'b0, 12'h004, 32'h0, rd, err);
    chk("status_clear", rd, 32'h00000000);
    apb(1'b0, 12'h008, 32'h0, rd, err);
    chk("last_opcode", rd, 32'h00000000);
    test_done();
  end
endmodule // testbench
